// >>> ddri_dev_model.sv
// device-side model: mode registers, dll lock and zq calibration timers
`timescale 1ns/1ns
module ddri_dev_model #(
  parameter int MOD_CYC    = 12,
  parameter int ZQINIT_CYC = 512
) (
  input  wire ddri_pkg::ddri_pins_s pins,    // pins from the controller
  input  wire logic                 clk,     // device clock
  output ddri_pkg::ddri_mode_s      mr,      // stored mode registers
  output logic                      odt_hiz, // termination held off
  output logic                      ready,   // normal operation allowed
  output int                        viol     // controller faults seen
);
  logic cke_seen;
  int   dll_cnt;
  int   zq_cnt;
  int   since_mrs;
  wire  rn     = pins.reset_n;
  wire  is_mrs = pins.cke && pins.cmd == ddri_pkg::CMD_MRS;
  wire  bad_c  = (cke_seen && !pins.cke && !ready) || (pins.odt && !ready);
  wire  bad_m  = pins.cmd != ddri_pkg::CMD_NOP && since_mrs + 1 < MOD_CYC;
  assign odt_hiz = !rn || !cke_seen;
  assign ready   = cke_seen && dll_cnt >= ddri_pkg::DLLK_CYC && zq_cnt >= ZQINIT_CYC;
  // mode loads never touch array contents; none is modelled
  always @(posedge clk or negedge rn) begin
    if (!rn) begin
      mr        <= '0;
      cke_seen  <= 1'b0;
      dll_cnt   <= 0;
      zq_cnt    <= -1;
      since_mrs <= 1000;
      viol      <= 0;
    end else begin
      viol <= viol + int'(bad_c) + int'(bad_m);
      if (pins.cke) cke_seen <= 1'b1;
      if (since_mrs < 1000) since_mrs <= since_mrs + 1;
      if (dll_cnt > 0 && dll_cnt < ddri_pkg::DLLK_CYC) dll_cnt <= dll_cnt + 1;
      if (zq_cnt >= 0 && zq_cnt < ZQINIT_CYC) zq_cnt <= zq_cnt + 1;
      if (pins.cke && pins.cmd == ddri_pkg::CMD_ZQC && pins.addr[ddri_pkg::ZQ_LONG_BIT]) zq_cnt <= 0;
      if (is_mrs) begin
        since_mrs <= 0;
        case (pins.ba)
          ddri_pkg::BA_MR0: begin
            mr.mr0 <= pins.addr & ~(16'h0001 << ddri_pkg::MR0_DLL_RST_BIT);
            if (pins.addr[ddri_pkg::MR0_DLL_RST_BIT]) dll_cnt <= 1;
          end
          ddri_pkg::BA_MR1: mr.mr1 <= pins.addr;
          ddri_pkg::BA_MR2: mr.mr2 <= pins.addr;
          ddri_pkg::BA_MR3: mr.mr3 <= pins.addr;
          default: viol <= viol + 1;
        endcase
      end
    end
  end
endmodule

// >>> ddri_init_ctrl.sv
// module: ddr3 power-up initialization and mode-register load controller
//
// How it works
// - hold device reset low at least 200 us before starting initialization.
// - drive cke low at least 10 ns before releasing reset.
// - after reset release keep cke low 500 us less one clock.
// - raise cke synchronously, then issue only nop or deselect.
// - clock runs at least 10 ns and five cycles before cke high.
// - odt driven low before cke is first registered high.
// - cke stays high until initialization finishes.
// - after txpr load mr2, mr3, mr1, mr0 in that order.
// - mr2 selected with ba1 high, ba2 and ba0 low.
// - mr1 load enables the dll and sets termination.
// - mr0 load requests dll reset; 512 cycles to lock.
// - after mr0 issue long zq calibration, then wait tzqinit.
// - each mode load supplies every field of the register.
// - mode loads only with banks idle and precharged.
// - at least tmrd between two mode loads.
// - only nop or deselect until tmod after a mode load.
// - cke high from each mode load until tmrspden.
// - cas latency change needs txpdll before non-mode commands.
// - odt low from mode load until tmod when termination on.
`timescale 1ns/1ns
module ddri_init_ctrl #(
  parameter int RESET_CYC   = ddri_pkg::RESET_CYC,
  parameter int CKE_LOW_CYC = ddri_pkg::CKE_LOW_CYC,
  parameter int XPR_CYC     = ddri_pkg::XPR_CYC,
  parameter int MRD_CYC     = ddri_pkg::MRD_CYC,
  parameter int MOD_CYC     = ddri_pkg::MOD_CYC,
  parameter int ZQINIT_CYC  = ddri_pkg::ZQINIT_CYC
) (
  input  wire logic                        clk,      // 125 MHz clock
  input  wire logic                        rst,      // async reset, high
  input  wire logic                        start,    // level: begin init
  input  wire ddri_pkg::ddri_mode_s        mode,     // mode register values
  output ddri_pkg::ddri_pins_s             pins,     // device pins
  output logic                             busy,     // init running
  output logic                             done      // init complete
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ddri_pkg::ddri_state_s s_q;
  ddri_pkg::ddri_state_s s_d;

  localparam logic [ddri_pkg::CNT_W-1:0] C_RESET   = ddri_pkg::CNT_W'(RESET_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] C_CKEPRE  = ddri_pkg::CNT_W'(ddri_pkg::CKE_PRE_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] C_CKELOW  = ddri_pkg::CNT_W'(CKE_LOW_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] C_CLKPRE  = ddri_pkg::CNT_W'(ddri_pkg::CLK_PRE_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] C_XPR     = ddri_pkg::CNT_W'(XPR_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] C_MOD     = ddri_pkg::CNT_W'(MOD_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] C_MRD     = ddri_pkg::CNT_W'(MRD_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] C_ZQ      = ddri_pkg::CNT_W'(ZQINIT_CYC - 1);
  localparam logic [ddri_pkg::CNT_W-1:0] CNT_ZERO  = '0;
  localparam logic [9:0]                 C_DLLK    = 10'(ddri_pkg::DLLK_CYC - 1);

  // gap after an mrs: the longer of tmrd and tmod, so both hold
  localparam logic [ddri_pkg::CNT_W-1:0] C_MRS_GAP = (C_MOD > C_MRD) ? C_MOD : C_MRD;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pins.cmd  = ddri_pkg::CMD_NOP;
    s_d.pins.ba   = 3'h0;
    s_d.pins.addr = '0;
    if (s_q.cnt != CNT_ZERO) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
    if (s_q.dll_cnt != 10'h000) begin
      s_d.dll_cnt = s_q.dll_cnt - 1'b1;
    end
    case (s_q.st)
      ddri_pkg::ST_RESET: begin
        // reset low, cke low, odt low from the start
        if (start && s_q.cnt == CNT_ZERO) begin
          s_d.st  = ddri_pkg::ST_CKE_PRE;
          s_d.cnt = C_CKEPRE;
        end
      end
      ddri_pkg::ST_CKE_PRE: begin
        if (s_q.cnt == CNT_ZERO) begin
          s_d.pins.reset_n = 1'b1;
          s_d.st           = ddri_pkg::ST_CKE_LOW;
          s_d.cnt          = C_CKELOW;
        end
      end
      ddri_pkg::ST_CKE_LOW: begin
        if (s_q.cnt == CNT_ZERO) begin
          s_d.st  = ddri_pkg::ST_CLK_PRE;
          s_d.cnt = C_CLKPRE;
        end
      end
      ddri_pkg::ST_CLK_PRE: begin
        // clk has run since reset; keep five cycles margin anyway
        if (s_q.cnt == CNT_ZERO) begin
          s_d.pins.cke = 1'b1;
          s_d.pins.odt = 1'b0;
          s_d.st       = ddri_pkg::ST_XPR;
          s_d.cnt      = C_XPR;
        end
      end
      ddri_pkg::ST_XPR: begin
        if (s_q.cnt == CNT_ZERO) begin
          s_d.st     = ddri_pkg::ST_MRS;
          s_d.mr_idx = 2'h0;
        end
      end
      ddri_pkg::ST_MRS: begin
        // full register value each time, banks idle after reset
        s_d.pins.cmd = ddri_pkg::CMD_MRS;
        case (s_q.mr_idx)
          2'h0: begin
            s_d.pins.ba   = ddri_pkg::BA_MR2;
            s_d.pins.addr = mode.mr2;
          end
          2'h1: begin
            s_d.pins.ba   = ddri_pkg::BA_MR3;
            s_d.pins.addr = mode.mr3;
          end
          2'h2: begin
            s_d.pins.ba   = ddri_pkg::BA_MR1;
            s_d.pins.addr = mode.mr1;
            s_d.pins.addr[ddri_pkg::MR1_DLL_DIS_BIT] = 1'b0;
          end
          default: begin
            s_d.pins.ba   = ddri_pkg::BA_MR0;
            s_d.pins.addr = mode.mr0;
            s_d.pins.addr[ddri_pkg::MR0_DLL_RST_BIT] = 1'b1;
            s_d.dll_cnt   = C_DLLK;
          end
        endcase
        s_d.st  = ddri_pkg::ST_MRS_WAIT;
        s_d.cnt = C_MRS_GAP;
      end
      ddri_pkg::ST_MRS_WAIT: begin
        // nop only, cke held high, odt held low
        if (s_q.cnt == CNT_ZERO) begin
          if (s_q.mr_idx == 2'h3) begin
            s_d.st = ddri_pkg::ST_ZQ;
          end else begin
            s_d.mr_idx = s_q.mr_idx + 2'h1;
            s_d.st     = ddri_pkg::ST_MRS;
          end
        end
      end
      ddri_pkg::ST_ZQ: begin
        s_d.pins.cmd = ddri_pkg::CMD_ZQC;
        s_d.pins.addr[ddri_pkg::ZQ_LONG_BIT] = 1'b1;
        s_d.st  = ddri_pkg::ST_ZQ_WAIT;
        s_d.cnt = C_ZQ;
      end
      ddri_pkg::ST_ZQ_WAIT: begin
        if (s_q.cnt == CNT_ZERO && s_q.dll_cnt == 10'h000) begin
          s_d.st   = ddri_pkg::ST_DONE;
          s_d.done = 1'b1;
        end
      end
      ddri_pkg::ST_DONE: begin
        s_d.done = 1'b1;
      end
      default: begin
        s_d.st = ddri_pkg::ST_RESET;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.st           <= ddri_pkg::ST_RESET;
      s_q.cnt          <= C_RESET;
      s_q.mr_idx       <= 2'h0;
      s_q.dll_cnt      <= 10'h000;
      s_q.done         <= 1'b0;
      s_q.pins.reset_n <= 1'b0;
      s_q.pins.cke     <= 1'b0;
      s_q.pins.odt     <= 1'b0;
      s_q.pins.cmd     <= ddri_pkg::CMD_NOP;
      s_q.pins.ba      <= 3'h0;
      s_q.pins.addr    <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pins = s_q.pins;
  assign done = s_q.done;
  assign busy = ~s_q.done;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [ddri_pkg::CNT_W-1:0] since_rel_q;
  logic [ddri_pkg::CNT_W-1:0] since_mrs_q;
  logic                       seen_mrs_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_rel_q <= '0;
      since_mrs_q <= '0;
      seen_mrs_q  <= 1'b0;
    end else begin
      if (s_q.pins.reset_n && !s_q.pins.cke && since_rel_q != '1) begin
        since_rel_q <= since_rel_q + 1'b1;
      end
      if (s_q.pins.cmd == ddri_pkg::CMD_MRS) begin
        since_mrs_q <= '0;
        seen_mrs_q  <= 1'b1;
      end else if (since_mrs_q != '1) begin
        since_mrs_q <= since_mrs_q + 1'b1;
      end
    end
  end

  sequence mrs_cmd;
    s_q.pins.cmd == ddri_pkg::CMD_MRS;
  endsequence

  a_cke_after_low: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.pins.cke) |-> since_rel_q >= ddri_pkg::CNT_W'(CKE_LOW_CYC - 1))
    else $error("cke raised too early after reset release");
  a_reset_cke_low: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.pins.reset_n) |-> !s_q.pins.cke && $past(!s_q.pins.cke, 1))
    else $error("cke not low before reset release");
  a_cke_stays_high: assert property (@(posedge clk) disable iff (rst)
    s_q.pins.cke |=> s_q.pins.cke)
    else $error("cke dropped during init");
  a_odt_low_cke: assert property (@(posedge clk) disable iff (rst)
    $rose(s_q.pins.cke) |-> !s_q.pins.odt)
    else $error("odt high at cke rise");
  a_mrs_spacing: assert property (@(posedge clk) disable iff (rst)
    mrs_cmd and seen_mrs_q |-> $past(since_mrs_q, 1) >= ddri_pkg::CNT_W'(MRD_CYC - 1))
    else $error("mrs spacing below tmrd");
  a_nop_after_mrs: assert property (@(posedge clk) disable iff (rst)
    mrs_cmd |=> (s_q.pins.cmd == ddri_pkg::CMD_NOP) [*8])
    else $error("command issued inside tmod");
  a_first_mrs_mr2: assert property (@(posedge clk) disable iff (rst)
    mrs_cmd and !seen_mrs_q |-> s_q.pins.ba == ddri_pkg::BA_MR2)
    else $error("first mrs not to mr2");
  a_mr0_dll_rst: assert property (@(posedge clk) disable iff (rst)
    mrs_cmd and s_q.pins.ba == ddri_pkg::BA_MR0 |-> s_q.pins.addr[ddri_pkg::MR0_DLL_RST_BIT])
    else $error("mr0 load without dll reset");
  a_mr1_dll_on: assert property (@(posedge clk) disable iff (rst)
    mrs_cmd and s_q.pins.ba == ddri_pkg::BA_MR1 |-> !s_q.pins.addr[ddri_pkg::MR1_DLL_DIS_BIT])
    else $error("mr1 load disables dll");
  a_zq_after_mr0: assert property (@(posedge clk) disable iff (rst)
    s_q.pins.cmd == ddri_pkg::CMD_ZQC |-> s_q.mr_idx == 2'h3 && s_q.pins.addr[ddri_pkg::ZQ_LONG_BIT])
    else $error("zq calibration out of order");
  a_mrs_cke_high: assert property (@(posedge clk) disable iff (rst)
    mrs_cmd |-> s_q.pins.cke && s_q.pins.odt == 1'b0)
    else $error("mrs without cke high or with odt on");

endmodule

// >>> ddri_init_ctrl_tb.sv
// testbench: init sequence timing, mode loads and reset behaviour
`timescale 1ns/1ns
module ddri_init_ctrl_tb;
  localparam int RST_C = 20;
  localparam int LOW_C = 30;
  localparam int GAP   = (ddri_pkg::MOD_CYC > ddri_pkg::MRD_CYC) ? ddri_pkg::MOD_CYC : ddri_pkg::MRD_CYC;
  typedef struct packed { logic [2:0] ba; logic [15:0] addr; } ddri_row_s;
  logic                 clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 start = 1'b0;
  ddri_pkg::ddri_mode_s mode = '{mr0: 16'h1234, mr1: 16'h0045, mr2: 16'h0018, mr3: 16'h0004};
  ddri_pkg::ddri_pins_s pins;
  ddri_pkg::ddri_mode_s mr;
  logic                 busy, done, odt_hiz, ready, zq_long;
  int                   viol, cyc, t_rel, t_rn, t_cke, t_zq, t_done, err_count, samples_checked;
  ddri_row_s            got[$];
  int                   t_mrs[$];
  ddri_row_s            rows[4] = '{'{ddri_pkg::BA_MR2, 16'h0018}, '{ddri_pkg::BA_MR3, 16'h0004},
                                    '{ddri_pkg::BA_MR1, 16'h0044}, '{ddri_pkg::BA_MR0, 16'h1334}};
  always #4 clk = ~clk;
  ddri_init_ctrl #(.RESET_CYC(RST_C), .CKE_LOW_CYC(LOW_C)) dut (
    .clk(clk), .rst(rst), .start(start), .mode(mode), .pins(pins), .busy(busy), .done(done));
  ddri_dev_model #(.MOD_CYC(ddri_pkg::MOD_CYC), .ZQINIT_CYC(ddri_pkg::ZQINIT_CYC)) u_dev (
    .pins(pins), .clk(clk), .mr(mr), .odt_hiz(odt_hiz), .ready(ready), .viol(viol));
  // ---------------------------------------------------------------
  // event log, sampled mid-cycle
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    cyc <= cyc + 1;
    if (rst) t_rel <= cyc;
    if (pins.reset_n === 1'b1 && t_rn < 0) t_rn <= cyc;
    if (pins.cke === 1'b1 && t_cke < 0) t_cke <= cyc;
    if (pins.cmd === ddri_pkg::CMD_MRS) begin
      got.push_back({pins.ba, pins.addr});
      t_mrs.push_back(cyc);
    end
    if (pins.cmd === ddri_pkg::CMD_ZQC && t_zq < 0) begin
      t_zq    <= cyc;
      zq_long <= pins.addr[ddri_pkg::ZQ_LONG_BIT];
    end
    if (done === 1'b1 && t_done < 0) t_done <= cyc;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
      err_count++;
    end
  endtask
  task automatic clear_log();
    t_rn = -1;
    t_cke = -1;
    t_zq = -1;
    t_done = -1;
    got.delete();
    t_mrs.delete();
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // full init from reset release; start is dropped once the sequence is under way
  task automatic run_init();
    int n;
    n = 0;
    start <= 1'b1;
    while (pins.reset_n !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    start <= 1'b0;
    while (done !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("done", 32'h1, done);
    chk("busy", 32'h0, busy);
    chk("reset_hold", 32'h1, t_rn - t_rel >= RST_C);
    chk("cke_after_rel", 32'h1, t_cke > t_rn);
    chk("cke_low_span", 32'h1, t_cke - t_rn >= LOW_C + ddri_pkg::CLK_PRE_CYC);
    chk("mrs_count", 32'h4, got.size());
    for (int i = 0; i < 4 && i < got.size(); i++) begin
      chk("mrs_field", rows[i], got[i]);
      if (i == 0) chk("xpr", 32'h1, t_mrs[0] - t_cke >= ddri_pkg::XPR_CYC);
      else chk("mrs_gap", 32'h1, t_mrs[i] - t_mrs[i-1] >= GAP);
    end
    chk("zq_long", 32'h1, zq_long);
    if (t_mrs.size() == 4) chk("zq_gap", 32'h1, t_zq - t_mrs[3] >= GAP);
    chk("zq_init", 32'h1, t_done - t_zq >= ddri_pkg::ZQINIT_CYC);
    if (t_mrs.size() == 4) chk("dll_lock", 32'h1, t_done - t_mrs[3] >= ddri_pkg::DLLK_CYC);
    chk("dev_ready", 32'h1, ready);
    chk("dev_mr", 32'h00180004, mr[31:0]);
    chk("dev_mr1", 32'h0044, 32'(mr.mr1));
    chk("dev_mr0", 32'h1234, mr.mr0);
    chk("dev_viol", 32'h0, viol);
    chk("odt_hiz", 32'h0, odt_hiz);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc = 0;
    t_rel = 0;
    err_count = 0;
    samples_checked = 0;
    clear_log();
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    run_init();
    $display("test init_sequence ended");
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pins_in_reset", 32'({3'h0, ddri_pkg::CMD_NOP, 19'h0}), 32'(pins));
    chk("odt_hiz_rst", 32'h1, odt_hiz);
    chk("mr_cleared", 32'h0, mr.mr1);
    $display("test reset_values ended");
    clear_log();
    @(posedge clk);
    rst <= 1'b0;
    repeat (RST_C + 10) @(posedge clk);
    @(negedge clk);
    chk("no_start_hold", 32'h0, pins.reset_n);
    start <= 1'b1;
    for (int n = 0; n < 1000 && got.size() < 2; n++) @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    chk("abort_cke", 32'h0, pins.cke);
    chk("abort_mr", 32'h0, mr.mr2);
    $display("test start_hold_and_abort ended");
    repeat (5) @(posedge clk);
    clear_log();
    rst <= 1'b0;
    run_init();
    $display("test init_after_abort ended");
    give_verdict();
  end
  initial begin
    #80000;
    err_count++;
    give_verdict();
  end
endmodule

// >>> ddri_pkg.sv
// package: constants and types for the ddr3 power-up init controller
package ddri_pkg;

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;

  // ---------------------------------------------------------------
  // timing figures in their own units
  // ---------------------------------------------------------------
  localparam int T_RESET_US   = 200;
  localparam int T_CKE_PRE_NS = 10;
  localparam int T_CKE_LOW_US = 500;
  localparam int T_CLK_PRE_NS = 10;
  localparam int T_CLK_PRE_MIN_CYC = 5;

  // ---------------------------------------------------------------
  // derived cycle counts (least times round up)
  // ---------------------------------------------------------------
  localparam int RESET_CYC    = (T_RESET_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CKE_PRE_CYC  = (T_CKE_PRE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CKE_LOW_CYC  = (T_CKE_LOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS - 1;
  localparam int CLK_PRE_NS_CYC = (T_CLK_PRE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CLK_PRE_CYC  = (CLK_PRE_NS_CYC > T_CLK_PRE_MIN_CYC) ? CLK_PRE_NS_CYC : T_CLK_PRE_MIN_CYC;
  localparam int DLLK_CYC     = 512;

  // default spacings in cycles (configurable at the top)
  localparam int XPR_CYC      = 32;
  localparam int MRD_CYC      = 4;
  localparam int MOD_CYC      = 12;
  localparam int ZQINIT_CYC   = 512;

  localparam int CNT_W        = 17;

  // ---------------------------------------------------------------
  // mode register select and bits
  // ---------------------------------------------------------------
  localparam logic [2:0] BA_MR0 = 3'h0;
  localparam logic [2:0] BA_MR1 = 3'h1;
  localparam logic [2:0] BA_MR2 = 3'h2;
  localparam logic [2:0] BA_MR3 = 3'h3;
  localparam int MR0_DLL_RST_BIT = 8;
  localparam int MR1_DLL_DIS_BIT = 0;
  localparam int ADDR_W = 16;

  // ---------------------------------------------------------------
  // command encodings {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_ZQC = 4'h6;
  localparam int ZQ_LONG_BIT = 10;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_CKE_PRE, ST_CKE_LOW, ST_CLK_PRE, ST_XPR,
    ST_MRS, ST_MRS_WAIT, ST_ZQ, ST_ZQ_WAIT, ST_DONE
  } ddri_state_e;

  typedef struct packed {
    logic              reset_n;
    logic              cke;
    logic              odt;
    logic [3:0]        cmd;
    logic [2:0]        ba;
    logic [ADDR_W-1:0] addr;
  } ddri_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0] mr0;
    logic [ADDR_W-1:0] mr1;
    logic [ADDR_W-1:0] mr2;
    logic [ADDR_W-1:0] mr3;
  } ddri_mode_s;

  typedef struct packed {
    ddri_state_e       st;
    logic [CNT_W-1:0]  cnt;
    logic [1:0]        mr_idx;
    logic [9:0]        dll_cnt;
    logic              done;
    ddri_pins_s        pins;
  } ddri_state_s;

endpackage
